/* File: rtl/dbghrc_defs.svh */
// constants for the debug halt/run control block
// assumes inclusion by bare name from rtl files
`ifndef DBGHRC_DEFS_SVH
`define DBGHRC_DEFS_SVH
`define DBGHRC_RAM_BASE     32'h0000_0400
`define DBGHRC_RAM_BYTES    64
`define DBGHRC_RAM_WORDS    16
`define DBGHRC_EXC_WORD     4'hf
`define DBGHRC_SAVE_WORD    4'he
`define DBGHRC_EXC_MARK     32'hffff_ffff
`define DBGHRC_OK_MARK      32'h0000_0000
`define DBGHRC_OP_NOP       2'h0
`define DBGHRC_OP_READ      2'h1
`define DBGHRC_OP_WRITE     2'h2
`define DBGHRC_SCAN_BITS    39
`define DBGHRC_ADDR_LSB     34
`define DBGHRC_OP_LSB       0
`define DBGHRC_INT_BIT      33
`define DBGHRC_DATA_LSB     2
`endif

/* File: rtl/dbghrc_pkg.sv */
// types for the debug halt/run control block
// assumes the defs header is included by users
package dbghrc_pkg;
    typedef enum logic [1:0] {
        DBGHRC_RUN,
        DBGHRC_EXEC,
        DBGHRC_PARK
    } dbghrc_hart_t;
    typedef logic [31:0] dbghrc_word_t;
endpackage : dbghrc_pkg

/* File: rtl/dbghrc_sync.sv */
// two-flop synchroniser for pin-level inputs
// assumes asynchronous active-low reset in the sampling domain
module dbghrc_sync (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    // async in, sync out
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;
    logic q_r;
    // first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule : dbghrc_sync

/* File: rtl/dbghrc_top.sv */
// debug transport data scan, debug RAM and hart halt/run control
// assumes scan pins from the debugger, hart events as same-clock levels
// Summary of operation
// [RL1] The debugger loads the halt program into debug RAM before raising the debug interrupt.
// [RL2] The halt program sets the halt bit before jumping to the resume entry.
// [RL3] Each Update-DR of a write scan reads the addressed RAM word and then writes it.
// [RL4] The next Capture-DR latches that read result, shifted out as the word's old contents.
// [RL5] A RAM write with the interrupt bit set raises the hart's debug interrupt and the hart runs the RAM program.
// [RL6] A memory read loads four fixed instruction words then the address in word 4 with interrupt set.
// [RL7] The memory data only appears in the scan after the follow-up read of word 4.
// [RL8] To run, the debugger clears halt notification directly then runs a program clearing halt.
// [RL9] The debugger restores scratch registers other than the two the ROM saves.
// [RL10] With step set the hart runs one instruction with interrupts off and re-enters debug mode.
// [RL11] The debugger prefers hardware single-step over a breakpoint.
// [RL12] An exception in a debug program updates no registers and all-ones goes to the last RAM word.
// [RL13] A clean debug program run leaves the last RAM word reading zero.
// [RL14] With halt set, resume parks the hart in debug ROM until the interrupt is raised again.
// [RL15] Debug RAM is 64 bytes at 0x400 with the save and exception words at its top.
module dbghrc_top
    import dbghrc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // scan pins
    input  wire logic        tck_i,
    input  wire logic        tdi_i,
    input  wire logic        capture_dr_i,
    input  wire logic        shift_dr_i,
    input  wire logic        update_dr_i,
    output logic             tdo_o,
    // hart side
    input  wire logic [31:0] hart_addr_i,
    input  wire logic        hart_we_i,
    input  wire logic [31:0] hart_wdata_i,
    output logic [31:0]      hart_rdata_o,
    input  wire logic        prog_done_i,
    input  wire logic        prog_exc_i,
    input  wire logic        step_retired_i,
    input  wire logic        halt_set_i,
    input  wire logic        halt_clr_i,
    input  wire logic        step_set_i,
    input  wire logic        haltnot_clr_i,
    // status
    output logic             debug_int_o,
    output logic             debug_mode_o,
    output logic             irq_enable_o,
    output logic             halt_o,
    output logic             step_o,
    output logic             haltnot_o
);
`include "dbghrc_defs.svh"
    localparam int unsigned SB = `DBGHRC_SCAN_BITS;
    // all scan pins cross by two flops before use
    logic tck_s, tdi_s, cap_s, sh_s, upd_s;
    logic [4:0] pin_raw;
    logic [4:0] pin_s;
    assign pin_raw = {tck_i, tdi_i, capture_dr_i, shift_dr_i, update_dr_i};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            dbghrc_sync u_sync (
                .sys_clk_i (sys_clk_i),
                .resetn_i  (resetn_i),
                .d_i       (pin_raw[gi]),
                .q_o       (pin_s[gi])
            );
        end
    endgenerate
    assign {tck_s, tdi_s, cap_s, sh_s, upd_s} = pin_s;

    // true when the address falls inside debug RAM
    function automatic logic ram_hit(input logic [31:0] a);
        ram_hit = (a >= `DBGHRC_RAM_BASE) && (a < `DBGHRC_RAM_BASE + `DBGHRC_RAM_BYTES); // see [RL15]
    endfunction : ram_hit

    dbghrc_word_t ram_r [`DBGHRC_RAM_WORDS];
    logic              tck_q_r, tck_q_nxt;
    logic [SB-1:0]     sr_r, sr_nxt;
    logic [31:0]       cap_r, cap_nxt;
    logic              tdo_r, tdo_nxt;
    logic              dint_r, dint_nxt;
    logic              halt_r, halt_nxt;
    logic              step_r, step_nxt;
    logic              hnot_r, hnot_nxt;
    logic [31:0]       hrd_r, hrd_nxt;
    dbghrc_hart_t      st_r, st_nxt;
    logic              rise, fall, upd_go, ram_we_j, ram_we_h, exc_we, clean_we;
    logic [3:0]        j_idx, h_idx;
    logic [1:0]        j_op;

    assign rise  = tck_s & ~tck_q_r;
    assign fall  = ~tck_s & tck_q_r;
    assign j_op  = sr_r[`DBGHRC_OP_LSB +: 2];
    assign j_idx = sr_r[`DBGHRC_ADDR_LSB +: 4];
    assign h_idx = hart_addr_i[5:2];
    assign upd_go   = rise & upd_s;
    assign ram_we_j = upd_go & (j_op == `DBGHRC_OP_WRITE);
    assign ram_we_h = hart_we_i & ram_hit(hart_addr_i) & (st_r == DBGHRC_EXEC);
    assign exc_we   = (st_r == DBGHRC_EXEC) & prog_exc_i;
    assign clean_we = (st_r == DBGHRC_EXEC) & prog_done_i & ~prog_exc_i;

    // scan path next state
    always_comb begin
        tck_q_nxt = tck_s;
        sr_nxt    = sr_r;
        cap_nxt   = cap_r;
        tdo_nxt   = tdo_r;
        if (upd_go && j_op != `DBGHRC_OP_NOP) begin
            cap_nxt = ram_r[j_idx]; // read before write, see [RL3]
        end
        if (rise && cap_s) begin
            sr_nxt = {{(SB-35){1'b0}}, dint_r, cap_r, 2'b00}; // old contents out, see [RL4]
        end else if (rise && sh_s) begin
            sr_nxt = {tdi_s, sr_r[SB-1:1]};
        end
        if (fall) begin
            tdo_nxt = sr_r[0];
        end
    end

    // hart run control next state
    always_comb begin
        st_nxt   = st_r;
        dint_nxt = dint_r;
        halt_nxt = halt_r;
        step_nxt = step_r;
        hnot_nxt = hnot_r;
        hrd_nxt  = ram_hit(hart_addr_i) ? ram_r[h_idx] : 32'h0000_0000;
        if (halt_set_i) halt_nxt = 1'b1; // see [RL2]
        else if (halt_clr_i) halt_nxt = 1'b0; // see [RL8]
        if (step_set_i) step_nxt = 1'b1;
        if (halt_set_i) hnot_nxt = 1'b1;
        else if (haltnot_clr_i) hnot_nxt = 1'b0; // set wins over clear
        unique case (st_r)
            DBGHRC_RUN, DBGHRC_PARK: begin
                if (dint_r) st_nxt = DBGHRC_EXEC; // see [RL5]
                else if (st_r == DBGHRC_RUN && step_r && step_retired_i) begin
                    st_nxt   = DBGHRC_PARK; // one instruction then back, see [RL10]
                    step_nxt = 1'b0;
                end
            end
            DBGHRC_EXEC: begin
                if (prog_done_i || prog_exc_i) begin
                    dint_nxt = 1'b0;
                    st_nxt   = (halt_nxt && !halt_clr_i) ? DBGHRC_PARK : DBGHRC_RUN; // see [RL14]
                end
            end
        endcase
        if (ram_we_j && sr_r[`DBGHRC_INT_BIT]) dint_nxt = 1'b1; // raise wins, see [RL5]
    end

    // debug RAM storage, debugger write has priority
    always_ff @(posedge sys_clk_i) begin
        if (ram_we_j) begin
            ram_r[j_idx] <= sr_r[`DBGHRC_DATA_LSB +: 32]; // write after read, see [RL3]
        end else if (exc_we) begin
            ram_r[`DBGHRC_EXC_WORD] <= `DBGHRC_EXC_MARK; // see [RL12]
        end else if (clean_we) begin
            ram_r[`DBGHRC_EXC_WORD] <= `DBGHRC_OK_MARK; // see [RL13]
        end else if (ram_we_h && !prog_exc_i) begin
            ram_r[h_idx] <= hart_wdata_i; // faulting store dropped, see [RL12]
        end
    end

    // state registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tck_q_r <= 1'b0;
            sr_r    <= '0;
            cap_r   <= 32'h0000_0000;
            tdo_r   <= 1'b0;
            dint_r  <= 1'b0;
            halt_r  <= 1'b0;
            step_r  <= 1'b0;
            hnot_r  <= 1'b0;
            hrd_r   <= 32'h0000_0000;
            st_r    <= DBGHRC_RUN;
        end else begin
            tck_q_r <= tck_q_nxt;
            sr_r    <= sr_nxt;
            cap_r   <= cap_nxt;
            tdo_r   <= tdo_nxt;
            dint_r  <= dint_nxt;
            halt_r  <= halt_nxt;
            step_r  <= step_nxt;
            hnot_r  <= hnot_nxt;
            hrd_r   <= hrd_nxt;
            st_r    <= st_nxt;
        end
    end

    assign tdo_o        = tdo_r;
    assign hart_rdata_o = hrd_r;
    assign debug_int_o  = dint_r;
    assign debug_mode_o = (st_r != DBGHRC_RUN);
    assign irq_enable_o = (st_r == DBGHRC_RUN) & ~step_r; // see [RL10]
    assign halt_o       = halt_r;
    assign step_o       = step_r;
    assign haltnot_o    = hnot_r;

    // assertions; ram is not reset, so read-back compares use case equality
    int_raise_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL5]
        ram_we_j && sr_r[`DBGHRC_INT_BIT] |=> debug_int_o) else $error("write with int bit did not raise");
    exec_entry_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL5]
        debug_int_o && st_r != DBGHRC_EXEC |=> st_r == DBGHRC_EXEC) else $error("hart ignored interrupt");
    read_first_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL3]
        ram_we_j |=> cap_r === $past(ram_r[j_idx])) else $error("update read not old word");
    capture_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL4]
        rise && cap_s && !sh_s |=> sr_r[33:2] === $past(cap_r)) else $error("capture lost read");
    exc_mark_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL12]
        exc_we && !ram_we_j |=> ram_r[`DBGHRC_EXC_WORD] == `DBGHRC_EXC_MARK) else $error("no exception mark");
    clean_mark_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL13]
        clean_we && !ram_we_j |=> ram_r[`DBGHRC_EXC_WORD] == 32'h0) else $error("no clean mark");
    park_halt_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL14]
        st_r == DBGHRC_PARK && !debug_int_o |=> st_r == DBGHRC_PARK) else $error("left park early");
    step_once_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see [RL10]
        st_r == DBGHRC_RUN && step_r && step_retired_i && !dint_r |=> debug_mode_o && !step_o)
        else $error("step did not return");
endmodule : dbghrc_top

/* File: testbench/dbghrc_scan_model.sv */
// debugger stand-in that drives the scan pins of the debug transport
// assumes the bench calls scan() and nothing else drives these pins
module dbghrc_scan_model (
    // scan pins towards the design
    output logic      tck_o,
    output logic      tdi_o,
    output logic      capture_dr_o,
    output logic      shift_dr_o,
    output logic      update_dr_o,
    // serial data back from the design
    input  wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // tck stands low outside frames
    initial begin
        tck_o = 1'b0;
        tdi_o = 1'b0;
        capture_dr_o = 1'b0;
        shift_dr_o = 1'b0;
        update_dr_o = 1'b0;
    end

    // one 125 ns tck period; pins only move while tck is low
    task automatic tick;
        #62.5 tck_o = 1'b1;
        #62.5 tck_o = 1'b0;
    endtask : tick

    // capture, 39 shifts lsb first, update; returns the data field shifted out
    task automatic scan(input logic [1:0] op, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] got);
        logic [38:0] sin;
        logic [38:0] sout;
        sin = {a, d, op};
        capture_dr_o = 1'b1;
        tick();
        capture_dr_o = 1'b0;
        shift_dr_o = 1'b1;
        // tdo moves some clocks after a fall, so sample it just before the rise
        for (int i = 0; i < 39; i++) begin
            tdi_o = sin[i];
            #62.5 sout[i] = tdo_i;
            tck_o = 1'b1;
            #62.5 tck_o = 1'b0;
        end
        shift_dr_o = 1'b0;
        update_dr_o = 1'b1;
        tick();
        update_dr_o = 1'b0;
        tdi_o = ~tdi_o;                             // idle line must not show a stale bit
        got = sout[33:2];
    endtask : scan
endmodule : dbghrc_scan_model

/* File: testbench/debug_halt_run_control_test.sv */
// bench for dbghrc_top: scan traffic, hart program runs, halt, step, reset
// assumes dbghrc_scan_model drives the scan pins and this bench plays the hart
`include "dbghrc_defs.svh"
module debug_halt_run_control_test
    import dbghrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [1:0] op; logic [4:0] a; dbghrc_word_t d; dbghrc_word_t e; logic c;} dbghrc_row_t;
    localparam logic [1:0] WR = `DBGHRC_OP_WRITE;
    localparam logic [1:0] RD = `DBGHRC_OP_READ;
    localparam logic [1:0] NP = `DBGHRC_OP_NOP;
    localparam dbghrc_word_t MEMVAL = 32'h5a5a_c3c3;
    logic        sys_clk_i;
    logic        resetn_i;
    logic        tck, tdi, cap, shf, upd, we;
    wire logic   tdo;
    wire logic [5:0] st;
    logic [31:0] addr, wdata, got;
    wire logic [31:0] rdata;
    logic [6:0]  ev;
    int          miscompares, checked;
    // memory read timeline; bit 31 of the data word doubles as the interrupt bit
    dbghrc_row_t rows [7] = '{
        '{WR, 5'd0, 32'h4100_2403, 32'h0, 1'b0},
        '{WR, 5'd1, 32'h0004_2483, 32'h0c0d_0000, 1'b1},
        '{WR, 5'd2, 32'h4090_2823, 32'h0c0d_0001, 1'b1},
        '{WR, 5'd3, 32'h3f80_006f, 32'h0c0d_0002, 1'b1},
        '{WR, 5'd4, 32'h8000_0123, 32'h0c0d_0003, 1'b1},
        '{RD, 5'd4, 32'h0, 32'h0c0d_0004, 1'b1},
        '{NP, 5'd0, 32'h0, MEMVAL, 1'b1}};

    // 200 MHz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    dbghrc_scan_model i_dbghrc_scan_model (.tck_o(tck), .tdi_o(tdi), .capture_dr_o(cap), .shift_dr_o(shf),
        .update_dr_o(upd), .tdo_i(tdo));
    dbghrc_top i_dbghrc_top (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tck_i(tck), .tdi_i(tdi),
        .capture_dr_i(cap), .shift_dr_i(shf), .update_dr_i(upd), .tdo_o(tdo), .hart_addr_i(addr),
        .hart_we_i(we), .hart_wdata_i(wdata), .hart_rdata_o(rdata), .prog_done_i(ev[6]), .prog_exc_i(ev[5]),
        .step_retired_i(ev[4]), .halt_set_i(ev[3]), .halt_clr_i(ev[2]), .step_set_i(ev[1]),
        .haltnot_clr_i(ev[0]), .debug_int_o(st[5]), .debug_mode_o(st[4]), .irq_enable_o(st[3]),
        .halt_o(st[2]), .step_o(st[1]), .haltnot_o(st[0]));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // bounded wait on one status bit
    task automatic wait_st(input int b, input logic want);
        int n;
        n = 0;
        while (st[b] !== want) begin
            @(negedge sys_clk_i);
            n++;
            if (n > 200) begin
                miscompares++;
                complete_run();
            end
        end
    endtask : wait_st

    // one-cycle hart event, settled by the following negedge
    task automatic pulse(input logic [6:0] e);
        @(posedge sys_clk_i);
        ev <= e;
        @(posedge sys_clk_i);
        ev <= 7'h00;
        @(negedge sys_clk_i);
    endtask : pulse

    // hart read data is registered, so look one cycle after the address
    task automatic hread(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        addr <= a;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(rdata, exp);
    endtask : hread

    // the hart runs the program: store the result unless it faults, then finish
    task automatic run_prog(input logic exc, input logic [6:0] extra);
        wait_st(5, 1'b1);
        wait_st(4, 1'b1);
        @(posedge sys_clk_i);
        addr <= 32'h0000_0410;
        wdata <= MEMVAL;
        we <= !exc;
        @(posedge sys_clk_i);
        we <= 1'b0;
        pulse(extra);
        pulse(exc ? 7'h20 : 7'h40);
        wait_st(5, 1'b0);
        hread(32'h0000_043c, exc ? 32'hffff_ffff : 32'h0);
    endtask : run_prog

    // reset, prefill, timeline rows, then the awkward cases
    initial begin
        resetn_i = 1'b0;
        we = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        ev = 7'h00;
        repeat (6) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        for (int i = 0; i < 16; i++) begin
            i_dbghrc_scan_model.scan(WR, 5'(i), 32'h0c0d_0000 | 32'(i), got);
        end
        foreach (rows[i]) begin
            i_dbghrc_scan_model.scan(rows[i].op, rows[i].a, rows[i].d, got);
            if (rows[i].c) check(got, rows[i].e);
            if (rows[i].op == WR && rows[i].d[31]) run_prog(1'b0, 7'h00);
        end
        hread(32'h0000_0400, 32'h4100_2403);
        hread(32'h0000_0440, 32'h0);
        // a faulting program leaves all ones in the last word, seen through the scan too
        i_dbghrc_scan_model.scan(WR, 5'd5, 32'h8000_0000, got);
        run_prog(1'b1, 7'h00);
        i_dbghrc_scan_model.scan(RD, 5'd15, 32'h0, got);
        i_dbghrc_scan_model.scan(NP, 5'd0, 32'h0, got);
        check(got, 32'hffff_ffff);
        // halt parks the hart; then clear notification, step out and back in
        i_dbghrc_scan_model.scan(WR, 5'd6, 32'h8000_0000, got);
        run_prog(1'b0, 7'h08);
        check(32'(st[4:2]), 32'h5);
        pulse(7'h01);
        check(32'(st[0]), 32'h0);
        i_dbghrc_scan_model.scan(WR, 5'd6, 32'h8000_0000, got);
        run_prog(1'b0, 7'h06);
        check(32'(st[4:1]), 32'h1);
        pulse(7'h10);
        wait_st(4, 1'b1);
        // reset in mid-run returns every status output to idle
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        check(32'(st), 32'h08);
        resetn_i <= 1'b1;
        // after release the capture register is clear, so a nop scan reads zero
        repeat (3) @(posedge sys_clk_i);
        i_dbghrc_scan_model.scan(NP, 5'd0, 32'h0, got);
        check(got, 32'h0);
        check(32'(st), 32'h08);
        complete_run();
    end
endmodule : debug_halt_run_control_test
